// >>> rtl/timer16_defs.vh
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH
// register byte addresses (word aligned)
`define ADDR_CONTROL 4'h0
`define ADDR_COUNT_LOW 4'h4
`define ADDR_COUNT_HIGH 4'h8
`define ADDR_STATUS 4'hc
// counter_control fields
`define CTL_RUN 0
`define CTL_SRC 1
`define CTL_SYNC_N 2
`define CTL_OSC_EN 3
`define CTL_PS_LO 4
`define CTL_PS_HI 5
`define CTL_WIDE 7
`define CTL_WRITE_MASK 8'hbf
`define CTL_RESET 8'h00
// status register fields
`define STAT_FLAG 0
`define STAT_IRQ_EN 1
// compare mode that resets the counter
`define MODE_SPECIAL_EVENT 4'hb
// instruction cycle is four oscillator periods
`define CYCLE_DIV 2'h3
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> rtl/timer16.v
`timescale 1ns/1ps
`include "timer16_defs.vh"
// Overview of operation
// - 16-bit up count in two bytes, wraps FFFF to 0000
// - wrap sets sticky overflow flag; request only when enable bit set
// - control bit 0 runs or holds the counter
// - after reset counter is off and control reads zero
// - internal source counts once per instruction cycle, oscillator over four
// - external source counts rising edges of clock pin or crystal
// - bits 5-4 prescale 1:1, 1:2, 1:4, 1:8
// - sync select clear syncs external clock; ignored for internal source
// - oscillator enable forces both crystal pins to inputs
// - crystal oscillator keeps running through sleep
// - special event trigger clears count, starts conversion, no overflow flag
// - trigger reset only guaranteed in timer or synchronized mode
// - low byte write beats a coincident trigger
// - compare pair acts as period in trigger mode
// - wide mode: high address is buffer, low read copies live high
// - wide mode: low write loads high byte from buffer together
// - wide mode: live high byte not directly accessible
// - low byte write clears prescaler, high byte write does not
// - control bit 6 reads zero, ignores writes
module timer16 #(
  parameter PS_WIDTH = 3
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_count_clock_pin,
  input wire crystal_clock,
  input wire sleep,
  input wire [3:0] compare_unit_mode,
  input wire compare_match,
  input wire converter_enable,
  input wire [1:0] port_c_direction,
  output reg [1:0] crystal_pins_oe_n,
  output reg crystal_osc_run,
  output reg overflow_irq,
  output reg conversion_start
);
  // ==========================================================
  // state
  reg [7:0] counter_control;
  reg [7:0] count_low_byte;
  reg [7:0] count_high_byte;
  reg [7:0] high_buffer;
  reg overflow_flag;
  reg overflow_irq_enable;
  reg [PS_WIDTH-1:0] prescale_count;
  reg [1:0] cycle_count;
  reg ext_sync1;
  reg ext_sync2;
  reg ext_prev;
  reg [3:0] aw_addr;
  reg aw_have;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_have;

  wire counter_run = counter_control[`CTL_RUN];
  wire clock_source_select = counter_control[`CTL_SRC];
  wire ext_sync_select_n = counter_control[`CTL_SYNC_N];
  wire crystal_osc_enable = counter_control[`CTL_OSC_EN];
  wire [1:0] input_prescale_select = counter_control[`CTL_PS_HI:`CTL_PS_LO];
  wire wide_access_enable = counter_control[`CTL_WIDE];

  function [PS_WIDTH-1:0] ps_limit;
    input [1:0] sel;
    begin
      ps_limit = (({{(PS_WIDTH-1){1'b0}}, 1'b1}) << sel) - 1'b1;
    end
  endfunction

  // ==========================================================
  // count source
  // external edge source: crystal when enabled, otherwise the pin
  wire ext_raw = crystal_osc_enable ? crystal_clock : ext_count_clock_pin;
  // async mode still samples once here; in this single-clock model the
  // unsynced path is a shorter detector, accepting metastability risk
  wire ext_level = ext_sync_select_n ? ext_sync1 : ext_sync2;
  wire ext_edge = ext_level & ~ext_prev;
  wire tick_in = clock_source_select ? ext_edge : (cycle_count == `CYCLE_DIV);
  wire tick = counter_run & tick_in & (prescale_count == ps_limit(input_prescale_select));
  wire [15:0] count_now = {count_high_byte, count_low_byte};
  wire [15:0] count_inc = count_now + 16'h0001;
  // trigger honoured only when counter is synchronized to aclk
  wire trig = (compare_unit_mode == `MODE_SPECIAL_EVENT) & compare_match
    & ~(clock_source_select & ext_sync_select_n);

  // ==========================================================
  // bus decode
  wire do_write = aw_have & w_have & ~s_axi_bvalid;
  wire do_read = s_axi_arvalid & s_axi_arready;
  wire wr_ctl = do_write & (aw_addr == `ADDR_CONTROL) & w_strb[0];
  wire wr_low = do_write & (aw_addr == `ADDR_COUNT_LOW) & w_strb[0];
  wire wr_high = do_write & (aw_addr == `ADDR_COUNT_HIGH) & w_strb[0];
  wire wr_stat = do_write & (aw_addr == `ADDR_STATUS) & w_strb[0];
  wire rd_low = do_read & (s_axi_araddr == `ADDR_COUNT_LOW);
  wire wr_known = (aw_addr == `ADDR_CONTROL) | (aw_addr == `ADDR_COUNT_LOW)
    | (aw_addr == `ADDR_COUNT_HIGH) | (aw_addr == `ADDR_STATUS);
  wire rd_known = (s_axi_araddr == `ADDR_CONTROL) | (s_axi_araddr == `ADDR_COUNT_LOW)
    | (s_axi_araddr == `ADDR_COUNT_HIGH) | (s_axi_araddr == `ADDR_STATUS);

  reg [7:0] rd_byte;
  always @* begin
    case (s_axi_araddr)
      `ADDR_CONTROL: rd_byte = counter_control & `CTL_WRITE_MASK;
      `ADDR_COUNT_LOW: rd_byte = count_low_byte;
      `ADDR_COUNT_HIGH: rd_byte = wide_access_enable ? high_buffer : count_high_byte;
      `ADDR_STATUS: rd_byte = {6'h00, overflow_irq_enable, overflow_flag};
      default: rd_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // axi-lite slave
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (do_read) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // counter core
  always @(posedge aclk) begin
    if (!aresetn) begin
      counter_control <= `CTL_RESET;
      count_low_byte <= 8'h00;
      count_high_byte <= 8'h00;
      high_buffer <= 8'h00;
      overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
      prescale_count <= {PS_WIDTH{1'b0}};
      cycle_count <= 2'h0;
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev <= 1'b0;
      crystal_pins_oe_n <= 2'h3;
      crystal_osc_run <= 1'b0;
      overflow_irq <= 1'b0;
      conversion_start <= 1'b0;
    end else begin
      cycle_count <= cycle_count + 2'h1;
      ext_sync1 <= ext_raw;
      ext_sync2 <= ext_sync1;
      ext_prev <= ext_level;
      if (wr_ctl)
        counter_control <= w_data[7:0] & `CTL_WRITE_MASK;
      if (wr_stat)
        overflow_irq_enable <= w_data[`STAT_IRQ_EN];
      // prescaler
      if (wr_low)
        prescale_count <= {PS_WIDTH{1'b0}};
      else if (counter_run & tick_in)
        prescale_count <= tick ? {PS_WIDTH{1'b0}} : prescale_count + 1'b1;
      // count update, write first, then trigger, then increment
      if (wr_low) begin
        count_low_byte <= w_data[7:0];
        if (wide_access_enable)
          count_high_byte <= high_buffer;
      end else if (trig) begin
        count_low_byte <= 8'h00;
        count_high_byte <= 8'h00;
      end else if (tick) begin
        count_low_byte <= count_inc[7:0];
        count_high_byte <= count_inc[15:8];
      end
      if (wr_high & ~wr_low) begin
        if (wide_access_enable)
          high_buffer <= w_data[7:0];
        else
          count_high_byte <= w_data[7:0];
      end
      if (rd_low & wide_access_enable)
        high_buffer <= count_high_byte;
      // flag: set wins over software clear; trigger never sets it
      if (tick & ~trig & ~wr_low & (count_now == 16'hffff))
        overflow_flag <= 1'b1;
      else if (wr_stat & ~w_data[`STAT_FLAG])
        overflow_flag <= 1'b0;
      overflow_irq <= overflow_flag & overflow_irq_enable;
      conversion_start <= trig & ~wr_low & converter_enable;
      crystal_pins_oe_n <= crystal_osc_enable ? 2'h3 : port_c_direction;
      crystal_osc_run <= crystal_osc_enable;
    end
  end
  // sleep does not gate the oscillator request
  wire unused_sleep = sleep;
endmodule // timer16

// >>> testbench/timer16_monitor.sv
`timescale 1ns/1ps
// ==========
// port checker
module timer16_monitor (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] compare_unit_mode,
  input wire compare_match,
  input wire converter_enable,
  input wire [1:0] port_c_direction,
  input wire [1:0] crystal_pins_oe_n,
  input wire crystal_osc_run,
  input wire conversion_start
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endsequence
  // held pair is performed one edge after the take, answer stands the edge after that
  chk_write_answer: assert property (wr_taken |-> ##2 wr_answer) else $error("write not answered");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  chk_osc_pins: assert property (crystal_osc_run |-> crystal_pins_oe_n == 2'b11) else $error("pins driven");
  chk_oe_follow: assert property ($past(aresetn) && !crystal_osc_run |-> crystal_pins_oe_n == $past(port_c_direction))
    else $error("pin enable wrong");
  chk_conv_cause: assert property (conversion_start |-> $past(compare_match) && $past(converter_enable)
    && $past(compare_unit_mode) == 4'hb) else $error("stray conversion");
  chk_conv_off: assert property (!converter_enable |=> !conversion_start) else $error("conversion while off");
endmodule // timer16_monitor

// >>> testbench/ext_pulse_source.sv
`timescale 1ns/1ps
// idle low between bursts, never free-running
module ext_pulse_source (
  output logic ext_count_clock_pin = 1'b0,
  output logic crystal_clock = 1'b0
);
  task automatic pulses(input int n, input bit xtal);
    repeat (n) begin
      #130;
      if (xtal) crystal_clock = 1'b1; else ext_count_clock_pin = 1'b1;
      #130;
      crystal_clock = 1'b0;
      ext_count_clock_pin = 1'b0;
    end
  endtask
endmodule // ext_pulse_source

// >>> testbench/test_timer16.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("FAIL %0t: got %h want %h", $time, g, e); end end
module test_timer16;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'hf, s_axi_araddr = 4'h0, compare_unit_mode = 4'hb;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic sleep = 1'b0, compare_match = 1'b0, converter_enable = 1'b0;
  logic [1:0] port_c_direction = 2'b01, s_axi_bresp, s_axi_rresp, crystal_pins_oe_n, rrsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic crystal_osc_run, overflow_irq, conversion_start, ext_count_clock_pin, crystal_clock;
  int n_fail = 0, samples_checked = 0, cyc = 0, t0;
  always #20 aclk = ~aclk;
  ext_pulse_source src (.ext_count_clock_pin(ext_count_clock_pin), .crystal_clock(crystal_clock));
  timer16 dut (.*);
  // ==========
  // bus tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    // late ready keeps the answer standing a cycle
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rdat, {24'h0, e})
  endtask
  task automatic end_sim;
    $display("checks %0d, failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  // ==========
  // scenarios
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(4'h0, 8'h00);
    wr(4'h0, 8'h48);
    rchk(4'h0, 8'h08);
    sleep <= 1'b1;
    port_c_direction <= 2'b10;
    repeat (3) @(posedge aclk);
    `CHK(crystal_osc_run, 1'b1)
    `CHK(crystal_pins_oe_n, 2'b11)
    for (int i = 0; i < 4; i++) begin
      wr(4'h8, 8'h00);
      wr(4'h0, {2'b00, i[1:0], i[0], i[1], 2'b11});
      repeat (20) @(posedge aclk);
      wr(4'h4, 8'h00);
      src.pulses(8, i[0]);
      repeat (4) @(posedge aclk);
      rchk(4'h4, 8'h08 >> i);
    end
    wr(4'h0, 8'h03);
    wr(4'h8, 8'hff);
    wr(4'h4, 8'hff);
    src.pulses(1, 1'b0);
    repeat (4) @(posedge aclk);
    rchk(4'h4, 8'h00);
    rchk(4'h8, 8'h00);
    rchk(4'hc, 8'h01);
    `CHK(overflow_irq, 1'b0)
    wr(4'hc, 8'h03);
    `CHK(overflow_irq, 1'b1)
    wr(4'hc, 8'h02);
    rchk(4'hc, 8'h02);
    `CHK(overflow_irq, 1'b0)
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h00);
    t0 = cyc;
    wr(4'h0, 8'h01);
    while (cyc < t0 + 400) @(posedge aclk);
    wr(4'h0, 8'h00);
    rchk(4'h4, 8'h64);
    repeat (40) @(posedge aclk);
    rchk(4'h4, 8'h64);
    wr(4'h8, 8'h12);
    converter_enable <= 1'b1;
    compare_match <= 1'b1;
    @(posedge aclk);
    compare_match <= 1'b0;
    repeat (3) @(posedge aclk);
    rchk(4'h4, 8'h00);
    rchk(4'h8, 8'h00);
    rchk(4'hc, 8'h02);
    wr(4'h0, 8'h80);
    wr(4'h8, 8'hab);
    rchk(4'h8, 8'hab);
    rchk(4'h4, 8'h00);
    rchk(4'h8, 8'h00);
    wr(4'h8, 8'h5a);
    wr(4'h4, 8'h3c);
    wr(4'h0, 8'h00);
    rchk(4'h8, 8'h5a);
    rchk(4'h4, 8'h3c);
    fork
      wr(4'h4, 8'h77);
      begin
        @(posedge aclk);
        compare_match <= 1'b1;
        @(posedge aclk);
        compare_match <= 1'b0;
      end
    join
    rchk(4'h4, 8'h77);
    rchk(4'h8, 8'h5a);
    wr(4'h0, 8'h06);
    compare_match <= 1'b1;
    @(posedge aclk);
    compare_match <= 1'b0;
    repeat (3) @(posedge aclk);
    rchk(4'h4, 8'h77);
    wr(4'h0, 8'h00);
    rd(4'h2);
    `CHK(rrsp, 2'h2)
    end_sim();
  end
endmodule // test_timer16
bind timer16 timer16_monitor mon (.*);
